/* File: shared/acc_pkg.sv */
// Package: constants, types and register map of the converter control block
// Functional notes
// - Start bit begins conversion of selected channel
// - Completion stores result, sets flag, raises irq
// - Start bit clears itself after start
// - Reading result clears the done flag
// - Restart clears flag, old result kept
// - Low-power entry aborts, resets controls, drops result if converting
// - No automatic resume after low-power return
// - Low-power entry disconnects the reference ladder
// - Result is unsigned eight bits
// - Six channels sampled only when analog
// - Busy set on start, cleared on finish/low-power
// - Channel codes 0 to 5 valid, rest reserved
// - Conversion time codes map to fc counts
// - Controls held at reset during low-power
package acc_pkg;
   // Register offsets
   localparam logic [7:0] OFS_CTRL1   = 8'h0e;
   localparam logic [7:0] OFS_CTRL2   = 8'h0f;
   localparam logic [7:0] OFS_RESULT  = 8'h20;
   localparam logic [7:0] OFS_STATUS  = 8'h21;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h22;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h23;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
   // Control 1 field positions
   localparam int CTRL1_START_BIT = 7;
   localparam int CTRL1_DIS_BIT   = 4;
   // Control 2 field positions
   localparam int CTRL2_LADDER_BIT = 5;
   localparam int CTRL2_TIME_LSB   = 1;
   // Status field positions
   localparam int STAT_DONE_BIT = 5;
   localparam int STAT_BUSY_BIT = 4;
   // Reset values
   localparam logic [7:0] CTRL1_RESET = 8'h10;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   // Reserved code limits
   localparam logic [3:0] CHAN_LAST = 4'h5;
   localparam int NUM_CHANNELS = 6;
   // Conversion lengths in fc periods
   localparam int CONV_T0 = 39;
   localparam int CONV_T2 = 78;
   localparam int CONV_T3 = 156;
   localparam int CONV_T4 = 312;
   localparam int CONV_T5 = 624;
   localparam int CONV_T6 = 1248;
   localparam int CNT_W = 11;

   // Control register 1 layout
   typedef struct packed {
      logic       start;
      logic [1:0] fixed;
      logic       input_disable;
      logic [3:0] channel;
   } acc_ctrl1_t;

   // Control register 2 layout
   typedef struct packed {
      logic [1:0] unused;
      logic       ladder_connect;
      logic       fixed_one;
      logic [2:0] time_sel;
      logic       fixed_zero;
   } acc_ctrl2_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b11
   } acc_state_t;

   // Cycle count for a time code, zero for reserved
   function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] code);
      case (code)
         3'b000:  conv_cycles = CNT_W'(CONV_T0);
         3'b010:  conv_cycles = CNT_W'(CONV_T2);
         3'b011:  conv_cycles = CNT_W'(CONV_T3);
         3'b100:  conv_cycles = CNT_W'(CONV_T4);
         3'b101:  conv_cycles = CNT_W'(CONV_T5);
         3'b110:  conv_cycles = CNT_W'(CONV_T6);
         default: conv_cycles = '0;
      endcase
   endfunction
endpackage

/* File: test/acc_adc_control_tb.sv */
// Testbench: converter control scenarios over the register port
`timescale 1ns/1ps
`default_nettype none
module acc_adc_control_tb
   import acc_pkg::*;
;
   logic       CLK = 1'b0;
   logic       RESET = 1'b1;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic       LOW_POWER = 1'b0;
   logic [7:0] SAMPLE_VALUE, RDATA, rv, rv2;
   logic [5:0] CHANNEL_ENABLE;
   logic       LADDER_ON, SAMPLING, IRQ;
   int         err_count = 0;
   int         n_checks = 0;
   int         ncyc = 0; // Counted on the falling clock edge
   int         lens [6] = '{CONV_T0, CONV_T2, CONV_T3, CONV_T4, CONV_T5, CONV_T6};
   always #12.5 CLK = ~CLK;
   always @(negedge CLK) ncyc++;
   acc_adc_control dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .LOW_POWER(LOW_POWER), .SAMPLE_VALUE(SAMPLE_VALUE), .CHANNEL_ENABLE(CHANNEL_ENABLE),
      .LADDER_ON(LADDER_ON), .SAMPLING(SAMPLING), .IRQ(IRQ));
   acc_analog_model model (.clk(CLK), .chan_en(CHANNEL_ENABLE), .sample(SAMPLE_VALUE));
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string w);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", w, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 rv = RDATA;
   endtask
   // Result read then status read with no gap between strobes
   task automatic rd_pair(output logic [7:0] r0, output logic [7:0] r1);
      @(posedge CLK);
      ADDR <= OFS_RESULT;
      RD <= 1'b1;
      @(posedge CLK);
      ADDR <= OFS_STATUS;
      #1 r0 = RDATA;
      @(posedge CLK);
      RD <= 1'b0;
      #1 r1 = RDATA;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string w);
      rd(a);
      check(rv & m, e, w);
   endtask
   task automatic start(input logic [3:0] ch, input logic [2:0] tc);
      wr(OFS_CTRL1, {4'h2, ch});
      wr(OFS_CTRL2, {4'h1, tc, 1'b0});
      wr(OFS_CTRL1, {4'ha, ch});
   endtask
   // Polls the done flag; restarts only follow this; only status reads meanwhile
   task automatic wait_done;
      rv = 8'h00;
      for (int k = 0; k < 800 && rv[STAT_DONE_BIT] !== 1'b1; k++)
         rd(OFS_STATUS);
      check(rv[STAT_DONE_BIT], 1'b1, "done seen");
   endtask
   task automatic t_reset;
      rdchk(OFS_CTRL1, 8'hff, CTRL1_RESET, "ctrl1 reset");
      rdchk(OFS_CTRL2, 8'h3f, CTRL2_RESET, "ctrl2 reset");
      rdchk(8'h7f, 8'hff, 8'h00, "unmapped read");
      check(IRQ, 1'b0, "irq reset");
      $display("test reset finished");
   endtask
   // Each valid time code on its own pin, irq raised and cleared
   task automatic t_times;
      int t0;
      wr(OFS_IRQ_EN, 8'h01);
      for (int i = 0; i < 6; i++) begin
         start(4'(i), (i == 0) ? 3'h0 : 3'(i + 1));
         t0 = ncyc;
         repeat (2) @(posedge CLK);
         #1 check(CHANNEL_ENABLE, 8'(1 << i), "pin select");
         rdchk(OFS_CTRL1, 8'hff, {4'h2, 4'(i)}, "start self clear");
         rdchk(OFS_STATUS, 8'h30, 8'h10, "busy");
         wait_done;
         check(ncyc - t0 > lens[i] && ncyc - t0 <= lens[i] + 6, 1'b1, "length");
         rdchk(OFS_STATUS, 8'h30, 8'h20, "done flag");
         check(IRQ, 1'b1, "irq raised");
         rd_pair(rv, rv2);
         check(rv, 8'h30 + 8'(i) * 8'h11, "result");
         check(rv2 & 8'h30, 8'h00, "flag after read");
         wr(OFS_IRQ_CLR, 8'h01);
         @(posedge CLK);
         #1 check(IRQ, 1'b0, "irq cleared");
      end
      $display("test times finished");
   endtask
   task automatic t_restart;
      wr(OFS_IRQ_EN, 8'h00);
      start(4'h1, 3'h0);
      wait_done;
      check(IRQ, 1'b0, "irq masked");
      rdchk(OFS_IRQ_ST, 8'h01, 8'h01, "irq status");
      start(4'h4, 3'h2);
      rdchk(OFS_STATUS, 8'h20, 8'h00, "flag on restart");
      rdchk(OFS_RESULT, 8'hff, 8'h41, "old result kept");
      wait_done;
      rdchk(OFS_RESULT, 8'hff, 8'h74, "new result");
      wr(OFS_IRQ_CLR, 8'h03);
      $display("test restart finished");
   endtask
   // Low power in mid conversion, writes refused, no resume
   task automatic t_lowpower;
      start(4'h2, 3'h6);
      repeat (20) @(posedge CLK);
      #1 check(LADDER_ON, 1'b1, "ladder in use");
      @(posedge CLK);
      LOW_POWER <= 1'b1;
      wr(OFS_CTRL1, 8'h25);
      #1 check({SAMPLING, LADDER_ON}, 8'h00, "abort");
      rdchk(OFS_CTRL1, 8'hff, CTRL1_RESET, "ctrl1 held");
      rdchk(OFS_CTRL2, 8'h3f, CTRL2_RESET, "ctrl2 held");
      rdchk(OFS_RESULT, 8'hff, 8'h00, "result dropped");
      rdchk(OFS_IRQ_ST, 8'h02, 8'h02, "abort status");
      @(posedge CLK);
      LOW_POWER <= 1'b0;
      repeat (50) @(posedge CLK);
      rdchk(OFS_STATUS, 8'h30, 8'h00, "no resume");
      start(4'h0, 3'h1);
      repeat (60) @(posedge CLK);
      rdchk(OFS_STATUS, 8'h30, 8'h00, "reserved time");
      wr(OFS_CTRL1, 8'h26);
      #1 check(CHANNEL_ENABLE, 8'h00, "reserved pin");
      $display("test low power finished");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge CLK);
      RESET <= 1'b0;
      t_reset;
      t_times;
      t_restart;
      t_lowpower;
      test_done;
   end
   // Watchdog well beyond the longest conversions
   initial begin
      #1000000;
      err_count++;
      test_done;
   end
endmodule // acc_adc_control_tb
`default_nettype wire

/* File: test/acc_analog_model.sv */
// Analog source model: one fixed code per selected pin
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model
   import acc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [5:0] chan_en,
   output var  logic [7:0] sample
);
   logic [7:0] junk = 8'h5a; // Unselected value
   // Changes every cycle so a stale code cannot pass
   always @(posedge clk) junk <= ~junk + 8'h01;
   // Selected analog pin drives its own code
   always_comb begin
      sample = junk;
      for (int k = 0; k < NUM_CHANNELS; k++)
         if (chan_en == 6'(1 << k)) sample = 8'h30 + 8'(k) * 8'h11;
   end
endmodule // acc_analog_model
`default_nettype wire

/* File: test/acc_properties.sv */
// Checker: port-level properties of the converter control block
`timescale 1ns/1ps
`default_nettype none
module acc_checker
   import acc_pkg::*;
(
   // Clock and reset
   input wire logic       CLK,
   input wire logic       RESET,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   // Mode and analog side
   input wire logic       LOW_POWER,
   input wire logic [5:0] CHANNEL_ENABLE,
   input wire logic       LADDER_ON,
   input wire logic       SAMPLING
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   // A conversion only ever begins from a start write
   start_cause_a: assert property ($rose(SAMPLING) |-> $past(WR) && $past(ADDR) == OFS_CTRL1 && $past(WDATA[7]))
      else $error("conversion began without start write");
   start_quiet_a: assert property ($rose(SAMPLING) |-> !$past(LOW_POWER))
      else $error("conversion began in low power");
   min_len_a: assert property ($rose(SAMPLING) && !LOW_POWER |-> SAMPLING[*8])
      else $error("conversion far too short");
   // Low power held three cycles leaves the analog side quiet
   abort_idle_a: assert property (LOW_POWER[*3] |-> !SAMPLING && !LADDER_ON && CHANNEL_ENABLE == 6'h00)
      else $error("analog side active in low power");
   onehot_chan_a: assert property ($onehot0(CHANNEL_ENABLE))
      else $error("more than one pin selected");
   start_clear_a: assert property ($past(RD) && $past(ADDR) == OFS_CTRL1 |-> !RDATA[CTRL1_START_BIT])
      else $error("start bit read back as one");
   // Idle guard keeps a same-cycle completion out of the way
   read_clear_a: assert property (!SAMPLING ##1 RD && ADDR == OFS_RESULT && !SAMPLING ##1 RD && ADDR == OFS_STATUS
      |=> !RDATA[STAT_DONE_BIT])
      else $error("done flag survived result read");
   busy_flag_a: assert property ($past(RD) && $past(ADDR) == OFS_STATUS && SAMPLING == $past(SAMPLING)
      && $past(SAMPLING, 2) == $past(SAMPLING) |-> RDATA[STAT_BUSY_BIT] == $past(SAMPLING))
      else $error("busy flag disagrees with sampling");
endmodule // acc_checker
bind acc_adc_control acc_checker chk (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .LOW_POWER(LOW_POWER), .CHANNEL_ENABLE(CHANNEL_ENABLE), .LADDER_ON(LADDER_ON),
   .SAMPLING(SAMPLING));
`default_nettype wire

/* File: verilog/acc_adc_control.sv */
// Converter control top: registers, sequencer, interrupt and analog controls
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module acc_adc_control
   import acc_pkg::*;
#(
   parameter int RES_W = 8
)(
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RESET,
   // Register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output var  logic [7:0] RDATA,
   // Power mode
   input  wire logic       LOW_POWER,
   // Analog front end
   input  wire logic [7:0] SAMPLE_VALUE,
   output var  logic [5:0] CHANNEL_ENABLE,
   output var  logic       LADDER_ON,
   output var  logic       SAMPLING,
   // Interrupt
   output var  logic       IRQ
);
   // Width check
   if (RES_W != 8) begin : g_bad_width
      $error("Result width must be 8");
   end

   acc_ctrl1_t       ctrl1, next_ctrl1;     // Control register 1
   acc_ctrl2_t       ctrl2, next_ctrl2;     // Control register 2
   logic [RES_W-1:0] result, next_result;   // Conversion result
   logic             done_flag, next_done_flag;
   logic [1:0]       irq_st, next_irq_st;   // Sticky: bit0 done, bit1 abort
   logic [1:0]       irq_en, next_irq_en;
   logic [7:0]       next_rdata;
   logic             start_req;             // Start written this cycle
   logic             start_ok;              // Start accepted: idle and a valid time code
   logic             busy, done;            // From sequencer
   logic             aborting;              // Low power hit during conversion

   // Start request when start bit written outside low power
   assign start_req = WR && ADDR == OFS_CTRL1 && WDATA[CTRL1_START_BIT] && !LOW_POWER;
   assign aborting  = LOW_POWER && busy;
   // Reserved time codes start nothing, so the analog side must not wake for them
   assign start_ok  = start_req && !busy && conv_cycles(ctrl2.time_sel) != '0;

   // Sequencer, aborted by low-power entry
   acc_sequencer u_seq (
      .clk    (CLK),
      .reset  (RESET),
      .start  (start_ok),
      .abort  (LOW_POWER),
      .length (conv_cycles(ctrl2.time_sel)),
      .busy   (busy),
      .done   (done)
   );

   // Register next values
   always_comb begin
      next_ctrl1     = ctrl1;
      next_ctrl2     = ctrl2;
      next_result    = result;
      next_done_flag = done_flag;
      next_irq_st    = irq_st;
      next_irq_en    = irq_en;
      next_rdata     = 8'h00;
      // Start bit never stored; reads back as zero
      next_ctrl1.start = 1'b0;
      // Software writes
      if (WR) begin
         case (ADDR)
            OFS_CTRL1: begin
               next_ctrl1 = acc_ctrl1_t'(WDATA);
               next_ctrl1.start = 1'b0;
            end
            OFS_CTRL2:   next_ctrl2 = acc_ctrl2_t'(WDATA);
            OFS_IRQ_EN:  next_irq_en = WDATA[1:0];
            OFS_IRQ_CLR: next_irq_st = irq_st & ~WDATA[1:0];
            default: ;
         endcase
      end
      // Restart before the result read clears the flag, result kept
      if (start_req) begin
         next_done_flag = 1'b0;
      end
      // Reads; the result read clears the done flag
      if (RD) begin
         case (ADDR)
            OFS_CTRL1:  next_rdata = ctrl1;
            OFS_CTRL2:  next_rdata = ctrl2;
            OFS_RESULT: begin
               next_rdata     = result;
               next_done_flag = 1'b0;
            end
            OFS_STATUS: begin
               next_rdata[STAT_DONE_BIT] = done_flag;
               next_rdata[STAT_BUSY_BIT] = busy;
            end
            OFS_IRQ_ST: next_rdata = {6'h00, irq_st};
            OFS_IRQ_EN: next_rdata = {6'h00, irq_en};
            default:    next_rdata = 8'h00;
         endcase
      end
      // Completion wins over any clear in the same cycle
      if (done) begin
         next_result    = SAMPLE_VALUE;
         next_done_flag = 1'b1;
         next_irq_st[0] = 1'b1;
      end
      if (aborting) begin
         next_irq_st[1] = 1'b1;
      end
      // Low power: controls forced to reset, control writes ignored, result dropped if converting
      if (LOW_POWER) begin
         next_ctrl1 = acc_ctrl1_t'(CTRL1_RESET);
         next_ctrl2 = acc_ctrl2_t'(CTRL2_RESET);
         if (aborting) begin
            next_result    = RESULT_RESET;
            next_done_flag = 1'b0;
         end
      end
   end

   // Registers
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ctrl1     <= acc_ctrl1_t'(CTRL1_RESET);
         ctrl2     <= acc_ctrl2_t'(CTRL2_RESET);
         result    <= RESULT_RESET;
         done_flag <= 1'b0;
         irq_st    <= 2'b00;
         irq_en    <= 2'b00;
         RDATA     <= 8'h00;
      end else begin
         ctrl1     <= next_ctrl1;
         ctrl2     <= next_ctrl2;
         result    <= next_result;
         done_flag <= next_done_flag;
         irq_st    <= next_irq_st;
         irq_en    <= next_irq_en;
         RDATA     <= next_rdata;
      end
   end

   // Analog-side outputs and IRQ, registered
   always_ff @(posedge CLK) begin
      if (RESET) begin
         CHANNEL_ENABLE <= 6'h00;
         LADDER_ON      <= 1'b0;
         SAMPLING       <= 1'b0;
         IRQ            <= 1'b0;
      end else begin
         // One-hot enable only for a valid code with analog input enabled
         CHANNEL_ENABLE <= 6'h00;
         if (!next_ctrl1.input_disable && next_ctrl1.channel <= CHAN_LAST) begin
            CHANNEL_ENABLE <= 6'(6'h01 << next_ctrl1.channel[2:0]);
         end
         // Ladder off in low power, else always-on or during conversion
         LADDER_ON <= !LOW_POWER && (next_ctrl2.ladder_connect || start_ok || (busy && !done));
         SAMPLING  <= !LOW_POWER && (start_ok || (busy && !done));
         IRQ       <= |(next_irq_st & next_irq_en);
      end
   end
endmodule // acc_adc_control
`default_nettype wire

/* File: verilog/acc_sequencer.sv */
// Conversion sequencer: counts the selected conversion length
`timescale 1ns/1ps
`default_nettype none
module acc_sequencer
   import acc_pkg::*;
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // Control
   input  wire logic             start,
   input  wire logic             abort,
   input  wire logic [CNT_W-1:0] length,
   // Status
   output var  logic             busy,
   output var  logic             done
);
   acc_state_t       state;       // Current state
   acc_state_t       next_state;  // Next state
   logic [CNT_W-1:0] count;       // Elapsed cycles
   logic [CNT_W-1:0] next_count;
   logic [CNT_W-1:0] target;      // Latched length
   logic [CNT_W-1:0] next_target;

   // Next-state logic
   always_comb begin
      next_state  = state;
      next_count  = count;
      next_target = target;
      case (state)
         ST_IDLE, ST_DONE: begin
            next_state = ST_IDLE;
            if (start && length != '0) begin
               next_state  = ST_CONV;
               next_count  = CNT_W'(1);
               next_target = length;
            end
         end
         ST_CONV: begin
            // Completion in the cycle after the count reaches the length
            if (count == target) begin
               next_state = ST_DONE;
            end else begin
               next_count = count + CNT_W'(1);
            end
         end
         default: next_state = ST_IDLE;
      endcase
      // Abort parks the sequencer idle; only a fresh start leaves it
      if (abort) begin
         next_state = ST_IDLE;
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (reset) begin
         state  <= ST_IDLE;
         count  <= '0;
         target <= '0;
      end else begin
         state  <= next_state;
         count  <= next_count;
         target <= next_target;
      end
   end

   // Busy spans the counting; done is a one-cycle pulse
   assign busy = (state == ST_CONV);
   assign done = (state == ST_DONE);
endmodule // acc_sequencer
`default_nettype wire
